// [bench/reg_bank_chk.sv]
// Port checker for reg_bank.
// Assumes the bind below reaches every reg_bank instance.
`timescale 1ns/1ps
`default_nettype none
module reg_bank_chk
	import regconv_pkg::*;
(
	input wire logic       sys_clk,  // Clock.
	input wire logic       sys_rst,  // Reset.
	input var  reg_req_t   req,      // Request.
	input wire logic [7:0] rdata,    // Read data.
	input wire logic [7:0] out_pins, // Base value.
	input wire logic [5:0] ctrl,     // Control.
	input wire logic       dbg_ctrl  // Debug bit.
);
	logic [7:0]  o_r;
	logic [7:0]  w_r;
	logic [15:0] wa;
	assign wa = req.wr ? 16'h0001 << req.addr : 16'h0000;
	always_ff @(posedge sys_clk) begin
		o_r <= out_pins;
		w_r <= req.wdata;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_out; wa[1] |=> out_pins == w_r; endproperty
	a_out: assert property (p_out) else $error("base write");
	property p_ctl; wa[0] |=> ctrl == w_r[5:0]; endproperty
	a_ctl: assert property (p_ctl) else $error("ctrl write");
	property p_set; wa[2] |=> out_pins == (o_r | w_r); endproperty
	a_set: assert property (p_set) else $error("set alias");
	property p_clear; wa[3] |=> out_pins == (o_r & ~w_r); endproperty
	a_clear: assert property (p_clear) else $error("clear alias");
	property p_toggle; wa[4] |=> out_pins == (o_r ^ w_r); endproperty
	a_toggle: assert property (p_toggle) else $error("toggle alias");
	property p_rd;
		req.rd && req.addr inside {[4'h1:4'h4]} |=> rdata == o_r;
	endproperty
	a_rd: assert property (p_rd) else $error("pair read");
	property p_rsv; req.rd && req.addr == 4'h0 |=> rdata[7:6] == 2'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits");
	property p_srst; wa[7] && req.wdata == 8'hA5 |=>
		out_pins == 8'h00 && ctrl == 6'h00 && $stable(dbg_ctrl); endproperty
	a_srst: assert property (p_srst) else $error("soft reset");
endmodule
bind reg_bank reg_bank_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.req(req), .rdata(rdata), .out_pins(out_pins), .ctrl(ctrl),
	.dbg_ctrl(dbg_ctrl));
`default_nettype wire

// [bench/tb_reg_bank.sv]
// Self-checking bench for reg_bank; read results are checked in order.
// Assumes the checker is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_reg_bank import regconv_pkg::*;;
	logic       sys_clk = 0;
	logic       sys_rst = 1;
	reg_req_t   req = '0;
	logic [3:0] hw_status = 4'h0;
	logic [7:0] rdata, out_pins, cmd_pulse, m, d, q[$], cq[$];
	logic [5:0] ctrl;
	logic       dbg_ctrl;
	logic [3:0] a;
	int         bad_count = 0, compares = 0, seed = 32'hEA05, i;
	always #5 sys_clk = ~sys_clk;
	reg_bank dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
		.hw_status(hw_status), .rdata(rdata), .out_pins(out_pins),
		.ctrl(ctrl), .cmd_pulse(cmd_pulse), .dbg_ctrl(dbg_ctrl));
	task automatic op(input logic w, r, input logic [3:0] ad,
		input logic [7:0] wd);
		@(negedge sys_clk);
		req = '{w, r, ad, wd};
	endtask
	task automatic rd(input logic [3:0] ad, input logic [7:0] e);
		q.push_back(e);
		op(0, 1, ad, 8'h00);
	endtask
	task automatic chk(input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_cmd(input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t cmd exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic finish_test;
		if (q.size() != 0 || cq.size() != 0)
			bad_count++;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk) if (req.rd && !sys_rst) begin
		@(negedge sys_clk);
		chk(q.pop_front(), rdata);
	end
	always @(negedge sys_clk) if (!sys_rst && cmd_pulse !== 8'h00) begin
		chk_cmd(cq.pop_front(), cmd_pulse);
	end
	initial begin
		#50000;
		bad_count++;
		finish_test;
	end
	initial begin
		repeat (5) @(negedge sys_clk);
		sys_rst = 0;
		for (i = 0; i < 16; i++) rd(i[3:0], 8'h00);
		$display("reset values done");
		m = 8'h00;
		for (i = 0; i < 40; i++) begin
			a = 4'h1 + 4'($random(seed) & 3);
			d = 8'($random(seed));
			op(1, 0, a, d);
			m = a == 4'h1 ? d : a == 4'h2 ? m | d : a == 4'h3 ? m & ~d : m ^ d;
			rd(a, m);
		end
		$display("alias pairs done");
		d = 8'($random(seed)) & 8'h3F;
		op(1, 0, 4'h0, d);
		rd(4'h0, d);
		op(1, 0, 4'h0, 8'hFF);
		rd(4'h0, 8'h3F);
		op(1, 0, 4'h8, 8'hFF);
		rd(4'h8, 8'h01);
		hw_status = 4'hA;
		op(1, 0, 4'h5, 8'hFF);
		cq.push_back(8'h5A);
		op(1, 0, 4'h6, 8'h5A);
		rd(4'h5, 8'h0A);
		rd(4'h6, 8'h00);
		d = 8'($random(seed)) | 8'h01;
		cq.push_back(d);
		op(1, 0, 4'h6, d);
		cq.push_back(8'h3C);
		op(1, 0, 4'h6, 8'h3C);
		$display("access kinds done");
		op(1, 0, 4'h7, 8'hA5);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h8, 8'h01);
		op(0, 0, 4'h0, 8'h00);
		repeat (3) @(negedge sys_clk);
		$display("soft reset done");
		finish_test;
	end
endmodule
`default_nettype wire

// [inc/regconv_params.svh]
// Constants for the generic register bank: offsets, field layout, resets.
// Assumes an 8-bit register port with byte offsets inside one peripheral.
`ifndef REGCONV_PARAMS_SVH
`define REGCONV_PARAMS_SVH

`define OFS_CTRL        4'h0
`define OFS_OUT         4'h1
`define OFS_OUT_SET     4'h2
`define OFS_OUT_CLEAR   4'h3
`define OFS_OUT_TOGGLE  4'h4
`define OFS_STATUS      4'h5
`define OFS_CMD         4'h6
`define OFS_SRST        4'h7
`define OFS_DBGCTRL     4'h8

`define CTRL_MASK       8'h3F
`define OUT_MASK        8'hFF
`define DBG_MASK        8'h01
`define SRST_KEY        8'hA5

`define CTRL_RST        8'h00
`define OUT_RST         8'h00
`define DBG_RST         8'h00

`endif

// [inc/regconv_pkg.sv]
// Types shared by the register bank and its alias update unit.
// Assumes the constants header is compiled alongside.
`default_nettype none
package regconv_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		ALIAS_NONE   = 2'b00,
		ALIAS_SET    = 2'b01,
		ALIAS_CLEAR  = 2'b10,
		ALIAS_TOGGLE = 2'b11
	} alias_op_t;

endpackage
`default_nettype wire

// [logic/alias_update.sv]
// Next-value logic for a base register reached through set/clear/toggle
// aliases. Purely combinational; the caller holds the register.
`timescale 1ns/1ps
`default_nettype none
module alias_update
	import regconv_pkg::*;
(
	input  wire logic [7:0] base_r,    // Current base value.
	input  var  alias_op_t  op,        // Which alias is written.
	input  wire logic [7:0] wmask,     // Data written to the alias.
	output logic      [7:0] base_nxt   // Updated base value.
);
	always_comb begin
		unique case (op)
			ALIAS_SET:    base_nxt = base_r | wmask;
			ALIAS_CLEAR:  base_nxt = base_r & ~wmask;
			ALIAS_TOGGLE: base_nxt = base_r ^ wmask;
			ALIAS_NONE: base_nxt = base_r;
		endcase
	end
endmodule
`default_nettype wire

// [logic/reg_bank.sv]
// Example peripheral register bank showing read/write, set/clear/toggle, read-only and write-only bit access conventions.
// Assumes a synchronous 8-bit register port on sys_clk from the processor.
`timescale 1ns/1ps
`default_nettype none
`include "regconv_params.svh"
module reg_bank
	import regconv_pkg::*;
(
	input  wire logic       sys_clk,   // System clock, 100 MHz.
	input  wire logic       sys_rst,   // Asynchronous reset, active high.
	input  var  reg_req_t   req,       // Register access request.
	input  wire logic [3:0] hw_status, // Live state shown read-only.
	output logic      [7:0] rdata,     // Read data, valid cycle after rd.
	output logic      [7:0] out_pins,  // Base output register value.
	output logic      [5:0] ctrl,      // Control field.
	output logic      [7:0] cmd_pulse, // Write-only command strobes.
	output logic            dbg_ctrl   // Debug control bit.
);

////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_r;
	logic [7:0] out_r;
	logic [7:0] out_nxt;
	logic [7:0] dbg_r;
	logic [7:0] cmd_r;
	logic [7:0] rdata_r;
	logic [3:0] stat_r;
	logic       soft_rst;
	alias_op_t  op;

	function automatic logic hit(input reg_req_t r, input logic [3:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	// Soft reset needs a key so a stray write cannot wipe the peripheral.
	assign soft_rst = hit(req, `OFS_SRST) && (req.wdata == `SRST_KEY);

	always_comb begin
		op = ALIAS_NONE;
		if (hit(req, `OFS_OUT_SET)) begin
			op = ALIAS_SET;
		end else if (hit(req, `OFS_OUT_CLEAR)) begin
			op = ALIAS_CLEAR;
		end else if (hit(req, `OFS_OUT_TOGGLE)) begin
			op = ALIAS_TOGGLE;
		end
	end

	alias_update u_alias (
		.base_r   (out_r),
		.op       (op),
		.wmask    (req.wdata),
		.base_nxt (out_nxt)
	);

////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= `CTRL_RST;
		end else if (soft_rst) begin
			ctrl_r <= `CTRL_RST;
		end else if (hit(req, `OFS_CTRL)) begin
			ctrl_r <= req.wdata & `CTRL_MASK;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_r <= `OUT_RST;
		end else if (soft_rst) begin
			out_r <= `OUT_RST;
		end else if (hit(req, `OFS_OUT)) begin
			out_r <= req.wdata;
		end else begin
			out_r <= out_nxt;
		end
	end

	// Debug control survives the peripheral soft reset.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dbg_r <= `DBG_RST;
		end else if (hit(req, `OFS_DBGCTRL)) begin
			dbg_r <= req.wdata & `DBG_MASK;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_r <= 8'h00;
		end else if (hit(req, `OFS_CMD)) begin
			cmd_r <= req.wdata;
		end else begin
			cmd_r <= 8'h00;
		end
	end

	// Status comes from outside logic, so it is synchronised first.
	logic [3:0] stat_meta_r;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_meta_r <= 4'h0;
			stat_r      <= 4'h0;
		end else begin
			stat_meta_r <= hw_status;
			stat_r      <= stat_meta_r;
		end
	end

////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				`OFS_CTRL:    rdata_r <= ctrl_r & `CTRL_MASK;
				`OFS_OUT,
				`OFS_OUT_SET,
				`OFS_OUT_CLEAR,
				`OFS_OUT_TOGGLE: rdata_r <= out_r;
				`OFS_STATUS:  rdata_r <= {4'h0, stat_r};
				`OFS_DBGCTRL: rdata_r <= dbg_r;
				default:      rdata_r <= 8'h00;
			endcase
		end
	end

	assign rdata     = rdata_r;
	assign out_pins  = out_r;
	assign ctrl      = ctrl_r[5:0];
	assign cmd_pulse = cmd_r;
	assign dbg_ctrl  = dbg_r[0];
endmodule
`default_nettype wire
